/* File: hw/mpu_model_core.sv */
/*
 register set of the 8-bit processor model and first-byte decoder,
 reached as an AHB-Lite slave; a write to the execute register
 decodes and carries out one instruction on the register set.
 assumes: single-word transfers, one master, clk_sys domain only.
*/
`default_nettype none
module mpu_model_core
  import mpu_model_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  state_t s, n;
  dec_t dc;
  logic sel, execNow, wr;
  logic [7:0] op, x, r, m8, acc, cor;
  logic [15:0] opd, m16, ea, nxt, pc_offset_mode, w;
  logic [10:0] sum;
  logic [16:0] d16;

  function automatic dec_t decode(input logic [7:0] o);
    dec_t t;
    t.valid = VALID_MAP[o[7:4]][o[3:0]];
    t.accB = o[7] ? o[6] : o[4];
    t.len = 2'h1;
    t.mode = MD_INHERENT;
    case (o[7:4])
      4'h2: begin
        t.mode = MD_PCOFFSET;
        t.len = 2'h2;
      end
      4'h4, 4'h5: t.mode = MD_ACCUM;
      4'h6: begin
        t.mode = MD_INDEXED;
        t.len = 2'h2;
      end
      4'h7: begin
        t.mode = MD_LONGADDR;
        t.len = 2'h3;
      end
      default: begin
        if (o[7]) begin
          case (o[5:4])
            2'h0: begin
              t.mode = (o[3:0] == 4'hd) ? MD_PCOFFSET : MD_LITERAL;
              t.len = (o[3:0] == 4'hc || o[3:0] == 4'he) ? 2'h3 : 2'h2;
            end
            2'h1: begin
              t.mode = MD_DIRECT;
              t.len = 2'h2;
            end
            2'h2: begin
              t.mode = MD_INDEXED;
              t.len = 2'h2;
            end
            default: begin
              t.mode = MD_LONGADDR;
              t.len = 2'h3;
            end
          endcase
        end
      end
    endcase
    if (!t.valid) begin
      t.len = 2'h1;
      t.mode = MD_INHERENT;
    end
    return t;
  endfunction

  // result is {half carry, carry or borrow, overflow, sum}
  function automatic logic [10:0] addsub(input logic [7:0] a,
    input logic [7:0] bb, input logic ci, input logic sub);
    logic [7:0] k;
    logic [8:0] s9;
    logic [4:0] s5;
    logic cc;
    k = sub ? ~bb : bb;
    cc = sub ? ~ci : ci;
    s9 = {1'b0, a} + {1'b0, k} + {8'h00, cc};
    s5 = {1'b0, a[3:0]} + {1'b0, k[3:0]} + {4'h0, cc};
    return {s5[4], s9[8] ^ sub, (a[7] == k[7]) && (s9[7] != a[7]),
      s9[7:0]};
  endfunction

  function automatic logic taken(input logic [3:0] c,
    input logic [5:0] f);
    logic t;
    case (c[3:1])
      3'h0: t = 1'b1;
      3'h1: t = ~(f[FLG_C] | f[FLG_Z]);
      3'h2: t = ~f[FLG_C];
      3'h3: t = ~f[FLG_Z];
      3'h4: t = ~f[FLG_V];
      3'h5: t = ~f[FLG_N];
      3'h6: t = ~(f[FLG_N] ^ f[FLG_V]);
      default: t = ~(f[FLG_Z] | (f[FLG_N] ^ f[FLG_V]));
    endcase
    return t ^ c[0];
  endfunction

  function automatic logic [5:0] nz(input logic [5:0] f,
    input logic [7:0] v);
    logic [5:0] g;
    g = f;
    g[FLG_N] = v[7];
    g[FLG_Z] = (v == 8'h00);
    return g;
  endfunction

  function automatic logic [5:0] nzw(input logic [5:0] f,
    input logic [15:0] v);
    logic [5:0] g;
    g = f;
    g[FLG_N] = v[15];
    g[FLG_Z] = (v == 16'h0000);
    g[FLG_V] = 1'b0;
    return g;
  endfunction

  function automatic logic [31:0] rdMux(input state_t t,
    input logic [7:0] o);
    logic [31:0] v;
    v = 32'h0;
    case (o)
      OFF_PC: v[15:0] = t.pc;
      OFF_SP: v[15:0] = t.sp;
      OFF_IX: v[15:0] = t.ix;
      OFF_ACCA: v[7:0] = t.a;
      OFF_ACCB: v[7:0] = t.b;
      OFF_FLAGS: v[7:0] = {FLG_ONES, t.f}; // RQ7 RQ22
      OFF_EXEC: v[23:0] = {t.opd, t.op};
      OFF_DECODE: begin
        v[DS_VALID] = t.dec.valid;
        v[DS_LEN +: 2] = t.dec.len;
        v[DS_MODE +: 3] = t.dec.mode;
        v[DS_ACCB] = t.dec.accB;
        v[DS_TAKEN] = t.taken;
        v[DS_WAIT] = t.waiting;
        v[DS_OP +: 8] = t.op;
      end
      OFF_MEM: v[15:0] = t.mem;
      OFF_EADDR: v[15:0] = t.ea;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  always_comb begin
    n = s;
    op = hwdata[7:0];
    opd = hwdata[23:8];
    dc = decode(op); // RQ10
    m8 = (dc.mode == MD_LITERAL) ? opd[7:0] : s.mem[7:0]; // RQ12
    m16 = (dc.mode == MD_LITERAL) ? opd : s.mem;
    acc = dc.accB ? s.b : s.a; // RQ13
    pc_offset_mode = {{8{opd[7]}}, opd[7:0]};
    x = 8'h00;
    r = 8'h00;
    cor = 8'h00;
    sum = 11'h000;
    d16 = 17'h00000;
    w = 16'h0000;
    wr = 1'b0;
    case (dc.mode)
      MD_DIRECT: ea = {8'h00, opd[7:0]};
      MD_INDEXED: ea = s.ix + {8'h00, opd[7:0]}; // RQ3
      MD_LONGADDR: ea = opd;
      default: ea = 16'h0000;
    endcase
    nxt = s.pc + {14'h0000, dc.len}; // RQ9
    sel = hsel & hready & htrans[1];
    execNow = s.wrPend && (s.wrOff == OFF_EXEC);
    n.ready = 1'b1;
    n.resp = 1'b0;
    n.wrPend = sel & hwrite;
    n.wrOff = haddr[7:0];
    if (s.wrPend) begin
      case (s.wrOff)
        OFF_PC: n.pc = hwdata[15:0];
        OFF_SP: n.sp = hwdata[15:0];
        OFF_IX: n.ix = hwdata[15:0];
        OFF_ACCA: n.a = hwdata[7:0];
        OFF_ACCB: n.b = hwdata[7:0];
        OFF_FLAGS: n.f = hwdata[5:0];
        OFF_MEM: n.mem = hwdata[15:0];
        default: ;
      endcase
    end
    if (execNow) begin
      n.op = op;
      n.opd = opd;
      n.dec = dc;
      n.ea = ea;
      n.taken = 1'b0;
      n.waiting = 1'b0;
      n.pc = nxt; // RQ1
      if (!dc.valid) begin
        n.pc = nxt; // RQ23 RQ11
      end else if (op[7]) begin
        case (op[3:0])
          4'h0, 4'h1, 4'h2, 4'h9, 4'hb: begin
            sum = addsub(acc, m8, (op[3:0] == 4'h2 || op[3:0] == 4'h9)
              ? s.f[FLG_C] : 1'b0, ~op[3]); // RQ4
            r = sum[7:0];
            n.f = nz(s.f, r); // RQ5
            n.f[FLG_V] = sum[8];
            n.f[FLG_C] = sum[9];
            if (op[3]) n.f[FLG_H] = sum[10];
            wr = (op[3:0] != 4'h1);
          end
          4'h4, 4'h5, 4'h6, 4'h8, 4'ha: begin
            case (op[3:0])
              4'h6: r = m8;
              4'h8: r = acc ^ m8;
              4'ha: r = acc | m8;
              default: r = acc & m8;
            endcase
            n.f = nz(s.f, r);
            n.f[FLG_V] = 1'b0;
            wr = (op[3:0] != 4'h5);
          end
          4'h7: begin
            n.mem = {8'h00, acc};
            n.f = nz(s.f, acc);
            n.f[FLG_V] = 1'b0;
          end
          4'hc: begin
            d16 = {1'b0, s.ix} - {1'b0, m16};
            n.f[FLG_N] = d16[15];
            n.f[FLG_Z] = (d16[15:0] == 16'h0000);
            n.f[FLG_V] = (s.ix[15] != m16[15]) && (d16[15] != s.ix[15]);
          end
          4'hd: begin
            n.mem = nxt;
            n.sp = s.sp - RET_BYTES; // RQ2
            n.pc = (dc.mode == MD_PCOFFSET) ? nxt + pc_offset_mode : ea;
          end
          4'he: begin
            w = m16;
            if (op[6]) n.ix = w;
            else n.sp = w;
            n.f = nzw(s.f, w);
          end
          4'hf: begin
            w = op[6] ? s.ix : s.sp; // RQ21
            n.mem = w;
            n.f = nzw(s.f, w);
          end
          default: ;
        endcase
        if (wr) begin
          if (dc.accB) n.b = r;
          else n.a = r;
        end
      end else if (op[6]) begin
        x = (op[5:4] == 2'h0) ? s.a : (op[5:4] == 2'h1) ? s.b
          : s.mem[7:0]; // RQ14
        if (op[3:0] == 4'he) begin
          n.pc = ea;
        end else begin
          case (op[3:0])
            4'h0: begin
              r = 8'h00 - x;
              n.f[FLG_C] = (r != 8'h00);
              n.f[FLG_V] = (r == SIGN_BIT8);
            end
            4'h3: begin
              r = ~x;
              n.f[FLG_C] = 1'b1;
              n.f[FLG_V] = 1'b0;
            end
            4'h4: r = {1'b0, x[7:1]};
            4'h6: r = {s.f[FLG_C], x[7:1]};
            4'h7: r = {x[7], x[7:1]};
            4'h8: r = {x[6:0], 1'b0};
            4'h9: r = {x[6:0], s.f[FLG_C]};
            4'ha: begin
              r = x - 8'h01;
              n.f[FLG_V] = (x == SIGN_BIT8);
            end
            4'hc: begin
              r = x + 8'h01;
              n.f[FLG_V] = (x == POS_MAX8);
            end
            4'hd: begin
              r = x;
              n.f[FLG_V] = 1'b0;
              n.f[FLG_C] = 1'b0;
            end
            default: begin
              r = 8'h00;
              n.f[FLG_V] = 1'b0;
              n.f[FLG_C] = 1'b0;
            end
          endcase
          case (op[3:0])
            4'h4, 4'h6, 4'h7: n.f[FLG_C] = x[0];
            4'h8, 4'h9: n.f[FLG_C] = x[7];
            default: ;
          endcase
          n.f = nz(n.f, r);
          case (op[3:0])
            4'h4, 4'h6, 4'h7, 4'h8, 4'h9:
              n.f[FLG_V] = n.f[FLG_N] ^ n.f[FLG_C];
            default: ;
          endcase
          if (op[3:0] != 4'hd) begin
            case (op[5:4])
              2'h0: n.a = r;
              2'h1: n.b = r;
              default: n.mem = {s.mem[15:8], r};
            endcase
          end
        end
      end else if (op[7:4] == 4'h2) begin
        n.taken = taken(op[3:0], s.f); // RQ8
        if (n.taken) n.pc = nxt + pc_offset_mode; // RQ15
      end else begin
        case (op)
          OP_A_TO_FLAGS: n.f = s.a[5:0]; // RQ18
          OP_FLAGS_TO_A: n.a = {FLG_ONES, s.f};
          OP_IX_INC, OP_IX_DEC: begin
            n.ix = op[0] ? s.ix - 16'h0001 : s.ix + 16'h0001;
            n.f[FLG_Z] = (n.ix == 16'h0000);
          end
          OP_CLR_OVF, OP_SET_OVF: n.f[FLG_V] = op[0]; // RQ16
          OP_CLR_CARRY, OP_SET_CARRY: n.f[FLG_C] = op[0];
          OP_CLR_MASK, OP_SET_MASK: n.f[FLG_I] = op[0]; // RQ6
          OP_ACC_SUB, OP_ACC_CMP, OP_ACC_ADD: begin
            sum = addsub(s.a, s.b, 1'b0, ~op[3]); // RQ20
            n.f = nz(s.f, sum[7:0]);
            n.f[FLG_V] = sum[8];
            n.f[FLG_C] = sum[9];
            if (op[3]) n.f[FLG_H] = sum[10];
            if (op != OP_ACC_CMP) n.a = sum[7:0];
          end
          OP_A_TO_B, OP_B_TO_A: begin
            r = op[0] ? s.b : s.a;
            if (op[0]) n.a = r;
            else n.b = r;
            n.f = nz(s.f, r);
            n.f[FLG_V] = 1'b0;
          end
          OP_DEC_ADJ: begin
            if (s.f[FLG_H] || s.a[3:0] > 4'h9) cor = cor | BCD_LO_ADJ;
            if (s.f[FLG_C] || s.a[7:4] > 4'h9
              || (s.a[7:4] > 4'h8 && s.a[3:0] > 4'h9))
              cor = cor | BCD_HI_ADJ;
            sum = addsub(s.a, cor, 1'b0, 1'b0);
            n.a = sum[7:0];
            n.f = nz(s.f, sum[7:0]);
            n.f[FLG_V] = sum[8];
            n.f[FLG_C] = s.f[FLG_C] | cor[6];
          end
          OP_SP_TO_IX: n.ix = s.sp + 16'h0001; // RQ19
          OP_SP_INC: n.sp = s.sp + 16'h0001;
          OP_SP_DEC: n.sp = s.sp - 16'h0001;
          OP_IX_TO_SP: n.sp = s.ix - 16'h0001;
          OP_POP_A, OP_POP_B: begin
            n.sp = s.sp + 16'h0001;
            if (op[0]) n.b = s.mem[7:0];
            else n.a = s.mem[7:0];
          end
          OP_PUSH_A, OP_PUSH_B: begin
            n.mem = {8'h00, op[0] ? s.b : s.a};
            n.sp = s.sp - 16'h0001; // RQ2
          end
          OP_SUB_RET: begin
            n.pc = s.mem; // RQ17
            n.sp = s.sp + RET_BYTES;
          end
          OP_INT_RET: begin
            n.pc = s.mem;
            n.sp = s.sp + FRAME_BYTES;
          end
          OP_WAIT_INT: begin
            n.sp = s.sp - FRAME_BYTES;
            n.waiting = 1'b1;
          end
          OP_SW_TRAP: begin
            n.sp = s.sp - FRAME_BYTES;
            n.f[FLG_I] = 1'b1;
          end
          default: ;
        endcase
      end
    end
    n.rdata = (sel & ~hwrite) ? rdMux(n, haddr[7:0]) : 32'h0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) s <= RST_ST;
    else s <= n;
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.ready;
  assign hresp = s.resp;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  flagOnes_a: assert property (sel && !hwrite // RQ7
    && haddr[7:0] == OFF_FLAGS |=> hrdata[7:6] == FLG_ONES)
    else $error("flag pad bits not one");
  pcStep_a: assert property (execNow && op[7:4] == 4'h4 // RQ1
    |=> s.pc == $past(s.pc) + 16'h0001)
    else $error("pc did not advance by one");
  threeByte_a: assert property (execNow && dc.valid // RQ9
    && op[7:4] == 4'hb |=> ($past(op[3:0]) == 4'hd ? s.mem : s.pc)
    == $past(s.pc) + 16'h0003)
    else $error("long address length wrong");
  branchAlways_a: assert property (execNow // RQ15
    && op == OP_ALWAYS_BR |=> s.taken
    && s.pc == $past(s.pc) + 16'h0002 + $past(pc_offset_mode))
    else $error("always branch target wrong");
  undefinedNop_a: assert property (execNow && !dc.valid // RQ23
    |=> s.a == $past(s.a) && s.b == $past(s.b)
    && s.f == $past(s.f) && s.pc == $past(s.pc) + 16'h0001)
    else $error("unassigned code changed state");
  maskBit_a: assert property (execNow && op[7:1] == 7'h07 // RQ16
    |=> s.f[FLG_I] == $past(op[0]) ##1 s.f[FLG_I] == $past(s.f[FLG_I])
    || $past(s.wrPend))
    else $error("mask flag not set or cleared");
  flagsToA_a: assert property (execNow // RQ18
    && op == OP_FLAGS_TO_A |=> s.a == {FLG_ONES, $past(s.f)})
    else $error("flags not copied to a");
  pushA_a: assert property (execNow && op == OP_PUSH_A // RQ19
    |=> s.sp == $past(s.sp) - 16'h0001 && s.mem[7:0] == $past(s.a))
    else $error("push did not move stack");
  literalB_a: assert property (execNow && op[7:4] == 4'hc // RQ13
    && op[3:0] == 4'h6 |=> s.b == $past(opd[7:0])
    && s.a == $past(s.a))
    else $error("literal load hit wrong accumulator");
endmodule
`default_nettype wire

/* File: include/mpu_model_pkg.sv */
/*
 package: register map, field layout, opcode table and types
 for the programmer model and first-byte decoder.
 assumes: one AHB-Lite slave core on clk_sys imports it.
*/
`default_nettype none
// Operation
// RQ1: 16-bit program counter tracks current location
// RQ2: stack pointer addresses next free stack byte
// RQ3: index register holds data or base address
// RQ4: two 8-bit accumulators feed and take results
// RQ5: flags record N, Z, V, C, H
// RQ6: flag bit 4 is interrupt mask
// RQ7: flag bits 7 and 6 read one
// RQ8: flags decide conditional branch taken
// RQ9: instructions are one to three bytes
// RQ10: first byte alone gives operation and mode
// RQ11: 197 codes valid, 59 unassigned
// RQ12: following bytes give operand or address
// RQ13: 80-BF use A, C0-FF B; nibble picks mode
// RQ14: rows 40-7F single-operand on A, B, memory
// RQ15: codes 20-2F relative branches with offset
// RQ16: 0A-0F clear and set V, C, I
// RQ17: 39, 3B, 3E, 3F return, return, wait, trap
// RQ18: 06 copies A to flags, 07 back
// RQ19: pops, pushes and stack pointer moves decode
// RQ20: accumulator-to-accumulator operations at 10-1B
// RQ21: low nibble F stores stack pointer, index
// RQ22: flag bits H5 I4 N3 Z2 V1 C0
// RQ23: unassigned codes run as one-byte no-op
package mpu_model_pkg;
  localparam logic [7:0] OFF_PC = 8'h00, OFF_SP = 8'h04, OFF_IX = 8'h08;
  localparam logic [7:0] OFF_ACCA = 8'h0c, OFF_ACCB = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14, OFF_EXEC = 8'h18;
  localparam logic [7:0] OFF_DECODE = 8'h1c, OFF_MEM = 8'h20;
  localparam logic [7:0] OFF_EADDR = 8'h24;
  localparam logic [15:0] PC_RST = 16'h0000, SP_RST = 16'h0000;
  localparam logic [15:0] IX_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] FLG_RST = 6'h10;
  localparam int FLG_C = 0, FLG_V = 1, FLG_Z = 2, FLG_N = 3;
  localparam int FLG_I = 4, FLG_H = 5;
  localparam logic [1:0] FLG_ONES = 2'h3;
  localparam int DS_VALID = 0, DS_LEN = 1, DS_MODE = 3, DS_ACCB = 6;
  localparam int DS_TAKEN = 7, DS_WAIT = 8, DS_OP = 16;
  localparam logic [15:0] VALID_MAP [16] = '{16'hffc2, 16'h0ac3,
    16'hfffd, 16'hcaff, 16'hb7d9, 16'hb7d9, 16'hf7d9, 16'hf7d9,
    16'h7f77, 16'hdff7, 16'hfff7, 16'hfff7, 16'h4f77, 16'hcff7,
    16'hcff7, 16'hcff7};
  localparam logic [7:0] OP_A_TO_FLAGS = 8'h06, OP_FLAGS_TO_A = 8'h07;
  localparam logic [7:0] OP_IX_INC = 8'h08, OP_IX_DEC = 8'h09;
  localparam logic [7:0] OP_CLR_OVF = 8'h0a, OP_SET_OVF = 8'h0b;
  localparam logic [7:0] OP_CLR_CARRY = 8'h0c, OP_SET_CARRY = 8'h0d;
  localparam logic [7:0] OP_CLR_MASK = 8'h0e, OP_SET_MASK = 8'h0f;
  localparam logic [7:0] OP_ACC_SUB = 8'h10, OP_ACC_CMP = 8'h11;
  localparam logic [7:0] OP_A_TO_B = 8'h16, OP_B_TO_A = 8'h17;
  localparam logic [7:0] OP_DEC_ADJ = 8'h19, OP_ACC_ADD = 8'h1b;
  localparam logic [7:0] OP_ALWAYS_BR = 8'h20, OP_SP_TO_IX = 8'h30;
  localparam logic [7:0] OP_SP_INC = 8'h31, OP_POP_A = 8'h32;
  localparam logic [7:0] OP_POP_B = 8'h33, OP_SP_DEC = 8'h34;
  localparam logic [7:0] OP_IX_TO_SP = 8'h35, OP_PUSH_A = 8'h36;
  localparam logic [7:0] OP_PUSH_B = 8'h37, OP_SUB_RET = 8'h39;
  localparam logic [7:0] OP_INT_RET = 8'h3b, OP_WAIT_INT = 8'h3e;
  localparam logic [7:0] OP_SW_TRAP = 8'h3f;
  localparam logic [15:0] RET_BYTES = 16'h0002, FRAME_BYTES = 16'h0007;
  localparam logic [7:0] BCD_LO_ADJ = 8'h06, BCD_HI_ADJ = 8'h60;
  localparam logic [7:0] SIGN_BIT8 = 8'h80, POS_MAX8 = 8'h7f;
  typedef enum logic [2:0] {MD_INHERENT = 3'h0, MD_ACCUM = 3'h1,
    MD_PCOFFSET = 3'h2, MD_LITERAL = 3'h3, MD_DIRECT = 3'h4,
    MD_INDEXED = 3'h5, MD_LONGADDR = 3'h6} mode_t;
  typedef struct packed {
    logic valid;
    logic [1:0] len;
    mode_t mode;
    logic accB;
  } dec_t;
  typedef struct packed {
    logic [15:0] pc, sp, ix, mem, ea, opd;
    logic [7:0] a, b, op, wrOff;
    logic [5:0] f;
    dec_t dec;
    logic taken, waiting, wrPend, ready, resp;
    logic [31:0] rdata;
  } state_t;
  localparam state_t RST_ST = '{pc: PC_RST, sp: SP_RST, ix: IX_RST,
    a: ACC_RST, b: ACC_RST, f: FLG_RST, ready: 1'b1,
    dec: '{valid: 1'b0, len: 2'h0, mode: MD_INHERENT, accB: 1'b0},
    default: '0};
endpackage
`default_nettype wire

/* File: sim/bus_host_model.sv */
/*
 host model: a single AHB-Lite master doing whole-word transfers.
 assumes: one slave whose hreadyout comes back as hready.
*/
`default_nettype none
module bus_host_model (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/*
 testbench: register checks and instruction execution over the bus.
 assumes: the core imports mpu_model_pkg and answers with OKAY.
*/
`default_nettype none
module testbench
  import mpu_model_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fbit [3] = '{8'h02, 8'h01, 8'h10};
  logic [15:0] d;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int nValid = 0;

  mpu_model_core dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp)
  );
  bus_host_model host (
    .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffffffff);
    host.xfer(1'b0, a, 32'h0, q);
    n_checks++;
    if ((q & m) !== (e & m)) begin
      err_total++;
      $display("MISMATCH reg %h exp %h got %h", a, e & m, q & m);
    end
    if (hresp !== 1'b0) begin
      err_total++;
      $display("MISMATCH hresp exp 0 got %b", hresp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, q);
  endtask

  task automatic ex(input logic [7:0] op, input logic [15:0] o);
    wr(OFF_EXEC, {8'h0, o, op});
  endtask

  // expected decode status: mask byte then value byte
  function automatic logic [15:0] dx(input logic [7:0] op);
    logic [3:0] h;
    logic [3:0] l;
    logic v;
    logic mk;
    logic am;
    logic [1:0] n;
    logic [2:0] m;
    h = op[7:4];
    l = op[3:0];
    v = VALID_MAP[h][l];
    mk = v;
    m = MD_INHERENT;
    n = 2'h1;
    case (h)
      4'h2: m = MD_PCOFFSET;
      4'h4, 4'h5: m = MD_ACCUM;
      4'h6, 4'ha, 4'he: m = MD_INDEXED;
      4'h7, 4'hb, 4'hf: m = MD_LONGADDR;
      4'h9, 4'hd: m = MD_DIRECT;
      4'h8, 4'hc: m = MD_LITERAL;
      default: mk = 1'b0;
    endcase
    if (m == MD_LITERAL && l == 4'hd) begin
      mk = 1'b0;
    end
    if (v && m inside {MD_PCOFFSET, MD_INDEXED, MD_DIRECT}) begin
      n = 2'h2;
    end
    if (v && m == MD_LONGADDR) begin
      n = 2'h3;
    end
    if (v && m == MD_LITERAL) begin
      n = (l == 4'hc || l == 4'he) ? 2'h3 : 2'h2;
    end
    am = mk && h >= 4'h4 && h != 4'h6 && h != 4'h7;
    return {1'b0, am, {3{mk}}, 3'b111,
      1'b0, h >= 4'hc || h == 4'h5, m, n, v};
  endfunction

  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk(OFF_PC, 32'h0);
    chk(OFF_SP, 32'h0);
    chk(OFF_IX, 32'h0);
    chk(OFF_ACCA, 32'h0);
    chk(OFF_FLAGS, 32'hd0);
    wr(8'h40, 32'hffffffff);
    chk(8'h40, 32'h0);
    wr(OFF_FLAGS, 32'h3f);
    chk(OFF_FLAGS, 32'hff);
    wr(OFF_FLAGS, 32'h0);
    chk(OFF_FLAGS, 32'hc0);
    wr(OFF_IX, 32'h1abcd);
    chk(OFF_IX, 32'habcd);
    wr(OFF_ACCB, 32'h1a5);
    chk(OFF_ACCB, 32'ha5);
    // every first byte: valid and length; mode and accumulator only where the dx mask bits are set
    for (int i = 0; i < 256; i++) begin
      d = dx(i[7:0]);
      ex(i[7:0], 16'h0);
      chk(OFF_DECODE, {8'h0, i[7:0], 8'h0, d[7:0]},
        {8'h0, 8'hff, 8'h0, d[15:8]});
      if (q[0] === 1'b1) begin
        nValid++;
      end
    end
    n_checks++;
    if (nValid != 197) begin
      err_total++;
      $display("MISMATCH valid_count exp 197 got %0d", nValid);
    end
    for (int i = 0; i < 6; i++) begin
      wr(OFF_FLAGS, i[0] ? 32'h0 : 32'h3f);
      ex(OP_CLR_OVF + i[7:0], 16'h0);
      chk(OFF_FLAGS, i[0] ? 32'hc0 | fbit[i / 2]
        : 32'hff & ~fbit[i / 2]);
    end
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_PC, 32'h2000);
    ex(OP_ALWAYS_BR, 16'h0010);
    chk(OFF_PC, 32'h2012);
    ex(8'h27, 16'h0010);
    chk(OFF_PC, 32'h2014);
    chk(OFF_DECODE, 32'h0, 32'h80);
    wr(OFF_FLAGS, 32'h04);
    ex(8'h27, 16'h00fe);
    chk(OFF_PC, 32'h2014);
    chk(OFF_DECODE, 32'h80, 32'h80);
    wr(OFF_PC, 32'h1000);
    ex(8'h86, 16'h0042);
    chk(OFF_ACCA, 32'h42);
    ex(8'hc6, 16'h0081);
    chk(OFF_ACCB, 32'h81);
    wr(OFF_MEM, 32'h33);
    ex(8'hb6, 16'h4321);
    chk(OFF_ACCA, 32'h33);
    chk(OFF_EADDR, 32'h4321);
    ex(8'h02, 16'h0);
    chk(OFF_PC, 32'h1008);
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_ACCA, 32'h7f);
    ex(8'h8b, 16'h0001);
    chk(OFF_ACCA, 32'h80);
    chk(OFF_FLAGS, 32'hea);
    ex(OP_FLAGS_TO_A, 16'h0);
    chk(OFF_ACCA, 32'hea);
    wr(OFF_ACCA, 32'h15);
    ex(OP_A_TO_FLAGS, 16'h0);
    chk(OFF_FLAGS, 32'hd5);
    wr(OFF_ACCA, 32'h01);
    ex(8'h40, 16'h0);
    chk(OFF_ACCA, 32'hff);
    ex(8'h5f, 16'h0);
    chk(OFF_ACCB, 32'h0);
    wr(OFF_MEM, 32'h5);
    ex(8'h7c, 16'h1234);
    chk(OFF_MEM, 32'h6);
    wr(OFF_SP, 32'h100);
    wr(OFF_ACCA, 32'h55);
    ex(OP_PUSH_A, 16'h0);
    chk(OFF_MEM, 32'h55);
    chk(OFF_SP, 32'hff);
    ex(OP_SP_INC, 16'h0);
    chk(OFF_SP, 32'h100);
    ex(OP_SP_DEC, 16'h0);
    chk(OFF_SP, 32'hff);
    wr(OFF_MEM, 32'h77);
    ex(OP_POP_B, 16'h0);
    chk(OFF_ACCB, 32'h77);
    chk(OFF_SP, 32'h100);
    wr(OFF_ACCA, 32'h5);
    wr(OFF_ACCB, 32'h3);
    ex(OP_ACC_ADD, 16'h0);
    chk(OFF_ACCA, 32'h8);
    ex(OP_ACC_SUB, 16'h0);
    chk(OFF_ACCA, 32'h5);
    ex(OP_A_TO_B, 16'h0);
    chk(OFF_ACCB, 32'h5);
    wr(OFF_ACCB, 32'h1);
    ex(OP_B_TO_A, 16'h0);
    chk(OFF_ACCA, 32'h1);
    ex(OP_ACC_CMP, 16'h0);
    chk(OFF_FLAGS, 32'h04, 32'h04);
    wr(OFF_SP, 32'hbeef);
    ex(8'h9f, 16'h0010);
    chk(OFF_MEM, 32'hbeef);
    wr(OFF_IX, 32'h1234);
    ex(8'hdf, 16'h0010);
    chk(OFF_MEM, 32'h1234);
    wr(OFF_SP, 32'h200);
    ex(OP_SUB_RET, 16'h0);
    chk(OFF_PC, 32'h1234);
    chk(OFF_SP, 32'h202);
    wr(OFF_FLAGS, 32'h0);
    ex(OP_SW_TRAP, 16'h0);
    chk(OFF_FLAGS, 32'h10, 32'h10);
    chk(OFF_SP, 32'h1fb);
    ex(OP_WAIT_INT, 16'h0);
    chk(OFF_DECODE, 32'h100, 32'h100);
    wr(OFF_MEM, 32'h4321);
    ex(OP_INT_RET, 16'h0);
    chk(OFF_PC, 32'h4321);
    chk(OFF_DECODE, 32'h0, 32'h100);
    finish_test();
  end
endmodule
`default_nettype wire
